//--- rtl/csar_regbank.v
`timescale 1ns/1ps
`default_nettype none
`include "csar_regs_map.vh"
// Behaviour
// - status bits 0..4 record completion, branch, exception, trap, unconditional events.
// - status bits 5,6,12,13 record instruction address compare hits 1..4.
// - status bits 7..10 record data compare read/write hits for comparators 1,2.
// - status bit 11 records an event seen while debug interrupts disabled.
// - every reset loads the two-bit last reset kind at bits 22:23.
// - each map bit covers one 128MB region, bit 0 lowest.
// - data cacheable map at 0x3FA, 1 means cacheable.
// - write-through map at 0x3BA, 1 means write-through, 0 write-back.
// - fetch cacheable map at 0x3FB, same region layout.
// - data fault address at 0x3D5 captures the full faulting address.
// - two data compare value words at 0x3B6 and 0x3B7.
// - cause bit 0 set on fetch machine check, cleared otherwise.
// - cause bits 4..7 flag illegal, privileged, trap, unimplemented program faults.
// - cause bit 8 flags a storing instruction on data storage fault.
// - cause bit 9 flags a zone protection fault.
// - cause bits 12,13 flag floating-point and auxiliary unit faults.
// - cause bit 16 flags user zero fault; bits 17..31 reserved.
// - vector base register at 0x3D6 holds 16-bit prefix in bits 0:15.
// - instruction compare words keep bits 0:29, low two bits reserved.
// - debug status at 0x3F0 is read and cleared by writing ones.
// - debug interrupt allow is machine state bit 22.
module csar_regbank (
    // clock and reset
    input  wire        CLK,
    input  wire        SYS_RST,
    input  wire [1:0]  RESET_KIND,
    // special register access
    input  wire [9:0]  SPR_NUM,
    input  wire        SPR_WR,
    input  wire        SPR_RD,
    input  wire [31:0] SPR_WDATA,
    output reg  [31:0] SPR_RDATA,
    output reg         SPR_RVALID,
    // machine state
    input  wire        MSR_DBG_ALLOW,
    // debug events
    input  wire        EVT_INSN_DONE,
    input  wire        EVT_BRANCH,
    input  wire        EVT_EXCEPTION,
    input  wire        EVT_TRAP,
    input  wire        EVT_UNCOND,
    input  wire        EVT_INSN_HIT_1,
    input  wire        EVT_INSN_HIT_2,
    input  wire        EVT_INSN_HIT_3,
    input  wire        EVT_INSN_HIT_4,
    input  wire        EVT_DATA_RD_HIT_1,
    input  wire        EVT_DATA_WR_HIT_1,
    input  wire        EVT_DATA_RD_HIT_2,
    input  wire        EVT_DATA_WR_HIT_2,
    // exception capture
    input  wire        EXC_LOAD,
    input  wire        FETCH_MACHINE_CHECK,
    input  wire        ILLEGAL_OP_FLAG,
    input  wire        PRIVILEGE_FAULT_FLAG,
    input  wire        TRAP_TAKEN_FLAG,
    input  wire        UNIMPLEMENTED_OP_FLAG,
    input  wire        STORE_FAULT_FLAG,
    input  wire        ZONE_FAULT_FLAG,
    input  wire        FLOAT_UNIT_FAULT_FLAG,
    input  wire        AUX_UNIT_FAULT_FLAG,
    input  wire        USER_ZERO_FAULT_FLAG,
    input  wire        DFA_LOAD,
    input  wire [31:0] DFA_ADDR,
    // storage attribute lookup
    input  wire [4:0]  DATA_REGION,
    input  wire [4:0]  FETCH_REGION,
    output reg         DATA_CACHEABLE,
    output reg         DATA_WRITETHROUGH,
    output reg         FETCH_CACHEABLE,
    // vector prefix
    output reg  [15:0] VECTOR_BASE
);
    reg  [31:0] dbg_status_ff;
    reg  [31:0] nxt_dbg_status;
    reg  [31:0] exc_cause_ff;
    reg  [31:0] nxt_exc_cause;
    reg  [31:0] dfa_ff;
    reg  [31:0] dwt_map_ff;
    reg  [31:0] dc_map_ff;
    reg  [31:0] fc_map_ff;
    reg  [31:0] vbase_ff;
    reg  [31:0] rd_local_ff;
    reg         rd_mem_sel_ff;
    reg         rd_pend_ff;
    reg  [31:0] ev_set;
    reg  [31:0] sw_clr;
    reg  [31:0] rd_mux;
    reg         mem_hit;
    reg  [1:0]  mem_slot;
    reg  [31:0] mem_mask;
    reg         any_evt;
    wire [31:0] mem_rdata;

    // pick the map bit for one 128MB region, region 0 in bit 0
    function region_bit;
        input [31:0] map;
        input [4:0]  region;
        begin
            region_bit = map[`CSAR_REGION_TOP - region];
        end
    endfunction

    // write strobe aimed at one register; strobe and number passed in so @* sees them
    function spr_write;
        input       wr;
        input [9:0] sel;
        input [9:0] num;
        begin
            spr_write = wr && (sel == num);
        end
    endfunction

    // memory slot decode
    always @* begin
        mem_hit  = 1'b1;
        mem_slot = `CSAR_SLOT_DVC_A;
        mem_mask = `CSAR_MASK_ALL;
        case (SPR_NUM)
            `CSAR_SPR_DVC_A: begin
                mem_slot = `CSAR_SLOT_DVC_A;
            end
            `CSAR_SPR_DVC_B: begin
                mem_slot = `CSAR_SLOT_DVC_B;
            end
            `CSAR_SPR_IAC_A: begin
                mem_slot = `CSAR_SLOT_IAC_A;
                mem_mask = `CSAR_MASK_IAC;
            end
            `CSAR_SPR_IAC_B: begin
                mem_slot = `CSAR_SLOT_IAC_B;
                mem_mask = `CSAR_MASK_IAC;
            end
            default: begin
                mem_hit = 1'b0;
            end
        endcase
    end

    csar_word_mem u_mem (
        .clk        (CLK),
        .rst        (SYS_RST),
        .wr_en      (SPR_WR && mem_hit),
        .wr_addr    (mem_slot),
        .wr_data    (SPR_WDATA),
        .wr_mask    (mem_mask),
        .rd_addr    (mem_slot),
        .rd_data_ff (mem_rdata)
    );

    // debug event sets and software clears
    always @* begin
        ev_set = 32'h00000000;
        ev_set[`CSAR_DBS_INSN_DONE] = EVT_INSN_DONE;
        ev_set[`CSAR_DBS_BRANCH]    = EVT_BRANCH;
        ev_set[`CSAR_DBS_EXCEPT]    = EVT_EXCEPTION;
        ev_set[`CSAR_DBS_TRAP]      = EVT_TRAP;
        ev_set[`CSAR_DBS_UNCOND]    = EVT_UNCOND;
        ev_set[`CSAR_DBS_IA1]       = EVT_INSN_HIT_1;
        ev_set[`CSAR_DBS_IA2]       = EVT_INSN_HIT_2;
        ev_set[`CSAR_DBS_IA3]       = EVT_INSN_HIT_3;
        ev_set[`CSAR_DBS_IA4]       = EVT_INSN_HIT_4;
        ev_set[`CSAR_DBS_DR1]       = EVT_DATA_RD_HIT_1;
        ev_set[`CSAR_DBS_DW1]       = EVT_DATA_WR_HIT_1;
        ev_set[`CSAR_DBS_DR2]       = EVT_DATA_RD_HIT_2;
        ev_set[`CSAR_DBS_DW2]       = EVT_DATA_WR_HIT_2;
        any_evt = |ev_set;
        // events while debug interrupts are off leave an imprecise mark
        ev_set[`CSAR_DBS_IMPRECISE] = any_evt && !MSR_DBG_ALLOW;
        sw_clr = 32'h00000000;
        if (spr_write(SPR_WR, SPR_NUM, `CSAR_SPR_DBG_STAT)) begin
            sw_clr = SPR_WDATA & `CSAR_MASK_DBG_STAT;
        end
        // set wins over clear in the same cycle
        nxt_dbg_status = ((dbg_status_ff & ~sw_clr) | ev_set) & `CSAR_MASK_DBG_STAT;
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            dbg_status_ff <= `CSAR_RST_WORD;
            dbg_status_ff[`CSAR_DBS_RST_HI:`CSAR_DBS_RST_LO] <= RESET_KIND;
        end else begin
            dbg_status_ff <= nxt_dbg_status;
        end
    end

    // exception cause: hardware capture replaces the whole word
    always @* begin
        nxt_exc_cause = exc_cause_ff;
        if (spr_write(SPR_WR, SPR_NUM, `CSAR_SPR_EXC_CAUSE)) begin
            nxt_exc_cause = SPR_WDATA & `CSAR_MASK_EXC;
        end
        if (EXC_LOAD) begin
            nxt_exc_cause = 32'h00000000;
            nxt_exc_cause[`CSAR_EXC_MCHK_FETCH] = FETCH_MACHINE_CHECK;
            nxt_exc_cause[`CSAR_EXC_ILLEGAL]    = ILLEGAL_OP_FLAG;
            nxt_exc_cause[`CSAR_EXC_PRIV]       = PRIVILEGE_FAULT_FLAG;
            nxt_exc_cause[`CSAR_EXC_TRAP]       = TRAP_TAKEN_FLAG;
            nxt_exc_cause[`CSAR_EXC_UNIMPL]     = UNIMPLEMENTED_OP_FLAG;
            nxt_exc_cause[`CSAR_EXC_STORE]      = STORE_FAULT_FLAG;
            nxt_exc_cause[`CSAR_EXC_ZONE]       = ZONE_FAULT_FLAG;
            nxt_exc_cause[`CSAR_EXC_FPU]        = FLOAT_UNIT_FAULT_FLAG;
            nxt_exc_cause[`CSAR_EXC_APU]        = AUX_UNIT_FAULT_FLAG;
            nxt_exc_cause[`CSAR_EXC_USER_ZERO]  = USER_ZERO_FAULT_FLAG;
        end
    end

    // exception cause word
    always @(posedge CLK) begin
        if (SYS_RST) begin
            exc_cause_ff <= `CSAR_RST_WORD;
        end else begin
            exc_cause_ff <= nxt_exc_cause;
        end
    end

    // captured fault address, hardware capture wins over software
    always @(posedge CLK) begin
        if (SYS_RST) begin
            dfa_ff <= `CSAR_RST_WORD;
        end else if (DFA_LOAD) begin
            dfa_ff <= DFA_ADDR;
        end else if (spr_write(SPR_WR, SPR_NUM, `CSAR_SPR_DFA)) begin
            dfa_ff <= SPR_WDATA;
        end
    end

    // write-through map
    always @(posedge CLK) begin
        if (SYS_RST) begin
            dwt_map_ff <= `CSAR_RST_WORD;
        end else if (spr_write(SPR_WR, SPR_NUM, `CSAR_SPR_DWT_MAP)) begin
            dwt_map_ff <= SPR_WDATA;
        end
    end

    // data cacheable map
    always @(posedge CLK) begin
        if (SYS_RST) begin
            dc_map_ff <= `CSAR_RST_WORD;
        end else if (spr_write(SPR_WR, SPR_NUM, `CSAR_SPR_DC_MAP)) begin
            dc_map_ff <= SPR_WDATA;
        end
    end

    // fetch cacheable map
    always @(posedge CLK) begin
        if (SYS_RST) begin
            fc_map_ff <= `CSAR_RST_WORD;
        end else if (spr_write(SPR_WR, SPR_NUM, `CSAR_SPR_FC_MAP)) begin
            fc_map_ff <= SPR_WDATA;
        end
    end

    // vector base, reserved low half kept at zero
    always @(posedge CLK) begin
        if (SYS_RST) begin
            vbase_ff <= `CSAR_RST_WORD;
        end else if (spr_write(SPR_WR, SPR_NUM, `CSAR_SPR_VBASE)) begin
            vbase_ff <= SPR_WDATA & `CSAR_MASK_VBASE;
        end
    end

    // data-side region lookup
    always @(posedge CLK) begin
        if (SYS_RST) begin
            DATA_CACHEABLE    <= `CSAR_RST_BIT;
            DATA_WRITETHROUGH <= `CSAR_RST_BIT;
        end else begin
            DATA_CACHEABLE    <= region_bit(dc_map_ff, DATA_REGION);
            DATA_WRITETHROUGH <= region_bit(dwt_map_ff, DATA_REGION);
        end
    end

    // fetch-side region lookup
    always @(posedge CLK) begin
        if (SYS_RST) begin
            FETCH_CACHEABLE <= `CSAR_RST_BIT;
        end else begin
            FETCH_CACHEABLE <= region_bit(fc_map_ff, FETCH_REGION);
        end
    end

    // vector prefix output, one cycle behind the register
    always @(posedge CLK) begin
        if (SYS_RST) begin
            VECTOR_BASE <= `CSAR_RST_VBASE;
        end else begin
            VECTOR_BASE <= vbase_ff[31:16];
        end
    end

    // read decode, unmapped numbers read zero
    always @* begin
        case (SPR_NUM)
            `CSAR_SPR_DBG_STAT: begin
                rd_mux = dbg_status_ff;
            end
            `CSAR_SPR_EXC_CAUSE: begin
                rd_mux = exc_cause_ff;
            end
            `CSAR_SPR_DFA: begin
                rd_mux = dfa_ff;
            end
            `CSAR_SPR_DWT_MAP: begin
                rd_mux = dwt_map_ff;
            end
            `CSAR_SPR_DC_MAP: begin
                rd_mux = dc_map_ff;
            end
            `CSAR_SPR_FC_MAP: begin
                rd_mux = fc_map_ff;
            end
            `CSAR_SPR_VBASE: begin
                rd_mux = vbase_ff;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // read request stage: memory word arrives one edge after the request
    always @(posedge CLK) begin
        if (SYS_RST) begin
            rd_local_ff   <= `CSAR_RST_WORD;
            rd_mem_sel_ff <= `CSAR_RST_BIT;
            rd_pend_ff    <= `CSAR_RST_BIT;
        end else begin
            rd_local_ff   <= rd_mux;
            rd_mem_sel_ff <= mem_hit;
            rd_pend_ff    <= SPR_RD;
        end
    end

    // read answer: valid pulses one cycle, data holds until the next answer
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SPR_RDATA  <= `CSAR_RST_WORD;
            SPR_RVALID <= `CSAR_RST_BIT;
        end else begin
            SPR_RVALID <= rd_pend_ff;
            if (rd_pend_ff) begin
                SPR_RDATA <= rd_mem_sel_ff ? mem_rdata : rd_local_ff;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/csar_word_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "csar_regs_map.vh"
// small word store, registered read data
module csar_word_mem (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // write side
    input  wire        wr_en,
    input  wire [1:0]  wr_addr,
    input  wire [31:0] wr_data,
    input  wire [31:0] wr_mask,
    // read side
    input  wire [1:0]  rd_addr,
    output reg  [31:0] rd_data_ff
);
    reg [31:0] mem_ff [0:3];

    always @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data & wr_mask;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rd_data_ff <= `CSAR_RST_WORD;
        end else begin
            rd_data_ff <= mem_ff[rd_addr];
        end
    end
endmodule
`default_nettype wire

//--- shared/csar_regs_map.vh
`ifndef CSAR_REGS_MAP_VH
`define CSAR_REGS_MAP_VH
// special register numbers
`define CSAR_SPR_DVC_A      10'h3b6
`define CSAR_SPR_DVC_B      10'h3b7
`define CSAR_SPR_DWT_MAP    10'h3ba
`define CSAR_SPR_EXC_CAUSE  10'h3d4
`define CSAR_SPR_DFA        10'h3d5
`define CSAR_SPR_VBASE      10'h3d6
`define CSAR_SPR_DBG_STAT   10'h3f0
`define CSAR_SPR_IAC_A      10'h3f4
`define CSAR_SPR_IAC_B      10'h3f5
`define CSAR_SPR_DC_MAP     10'h3fa
`define CSAR_SPR_FC_MAP     10'h3fb
// word memory slots
`define CSAR_SLOT_DVC_A     2'h0
`define CSAR_SLOT_DVC_B     2'h1
`define CSAR_SLOT_IAC_A     2'h2
`define CSAR_SLOT_IAC_B     2'h3
// debug status fields, big-endian bit n sits at index 31-n
`define CSAR_DBS_INSN_DONE  31
`define CSAR_DBS_BRANCH     30
`define CSAR_DBS_EXCEPT     29
`define CSAR_DBS_TRAP       28
`define CSAR_DBS_UNCOND     27
`define CSAR_DBS_IA1        26
`define CSAR_DBS_IA2        25
`define CSAR_DBS_DR1        24
`define CSAR_DBS_DW1        23
`define CSAR_DBS_DR2        22
`define CSAR_DBS_DW2        21
`define CSAR_DBS_IMPRECISE  20
`define CSAR_DBS_IA3        19
`define CSAR_DBS_IA4        18
`define CSAR_DBS_RST_HI     9
`define CSAR_DBS_RST_LO     8
// exception cause fields
`define CSAR_EXC_MCHK_FETCH 31
`define CSAR_EXC_ILLEGAL    27
`define CSAR_EXC_PRIV       26
`define CSAR_EXC_TRAP       25
`define CSAR_EXC_UNIMPL     24
`define CSAR_EXC_STORE      23
`define CSAR_EXC_ZONE       22
`define CSAR_EXC_FPU        19
`define CSAR_EXC_APU        18
`define CSAR_EXC_USER_ZERO  15
// implemented-bit masks
`define CSAR_MASK_DBG_STAT  32'hfffc0300
`define CSAR_MASK_EXC       32'h8fcc8000
`define CSAR_MASK_VBASE     32'hffff0000
`define CSAR_MASK_IAC       32'hfffffffc
`define CSAR_MASK_ALL       32'hffffffff
// highest region number of the attribute maps
`define CSAR_REGION_TOP     5'd31
// reset values
`define CSAR_RST_WORD       32'h00000000
`define CSAR_RST_BIT        1'b0
`define CSAR_RST_VBASE      16'h0000
`endif

//--- testbench/csar_regbank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "csar_regs_map.vh"
module csar_regbank_chk (
    // clock and reset
    input wire        CLK,
    input wire        SYS_RST,
    // register access
    input wire [9:0]  SPR_NUM,
    input wire        SPR_WR,
    input wire        SPR_RD,
    input wire [31:0] SPR_WDATA,
    input wire        SPR_RVALID,
    // attribute lookup and prefix
    input wire [4:0]  DATA_REGION,
    input wire [4:0]  FETCH_REGION,
    input wire        DATA_CACHEABLE,
    input wire        DATA_WRITETHROUGH,
    input wire        FETCH_CACHEABLE,
    input wire [15:0] VECTOR_BASE
);
    // shadow copies of the three maps
    reg  [31:0] dc_ff;
    reg  [31:0] wt_ff;
    reg  [31:0] fc_ff;
    wire        dc_sel = dc_ff[5'h1f - DATA_REGION];
    wire        wt_sel = wt_ff[5'h1f - DATA_REGION];
    wire        fc_sel = fc_ff[5'h1f - FETCH_REGION];
    wire        vb_wr  = SPR_WR && (SPR_NUM == `CSAR_SPR_VBASE);
    always @(posedge CLK) begin
        if (SYS_RST) begin
            dc_ff <= 32'h00000000;
            wt_ff <= 32'h00000000;
            fc_ff <= 32'h00000000;
        end else if (SPR_WR) begin
            if (SPR_NUM == `CSAR_SPR_DC_MAP) dc_ff <= SPR_WDATA;
            if (SPR_NUM == `CSAR_SPR_DWT_MAP) wt_ff <= SPR_WDATA;
            if (SPR_NUM == `CSAR_SPR_FC_MAP) fc_ff <= SPR_WDATA;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    AST_RD_ANSWER: assert property (
        SPR_RD |-> ##[2:3] SPR_RVALID) else $error("read got no answer");
    AST_NO_SPURIOUS: assert property (
        SPR_RVALID |-> $past(SPR_RD, 2) || $past(SPR_RD, 3)) else $error("answer without read");
    AST_VBASE_WRITE: assert property (
        vb_wr |-> ##2 VECTOR_BASE == $past(SPR_WDATA[31:16], 2)) else $error("prefix not loaded");
    AST_VBASE_HOLD: assert property (
        $changed(VECTOR_BASE) |-> $past(vb_wr, 2) || $past(SYS_RST)) else $error("prefix moved");
    AST_RESET_OUT: assert property (disable iff (1'b0)
        SYS_RST |=> VECTOR_BASE == 16'h0000 && !SPR_RVALID) else $error("outputs not reset");
    AST_DC_LOOKUP: assert property (
        DATA_CACHEABLE == $past(dc_sel)) else $error("data cacheable wrong");
    AST_WT_LOOKUP: assert property (
        DATA_WRITETHROUGH == $past(wt_sel)) else $error("write-through wrong");
    AST_FC_LOOKUP: assert property (
        FETCH_CACHEABLE == $past(fc_sel)) else $error("fetch cacheable wrong");
    cover property (SPR_RVALID);
    cover property (vb_wr);
    cover property (DATA_CACHEABLE && FETCH_CACHEABLE);
endmodule
bind csar_regbank csar_regbank_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .SPR_NUM(SPR_NUM),
    .SPR_WR(SPR_WR), .SPR_RD(SPR_RD), .SPR_WDATA(SPR_WDATA), .SPR_RVALID(SPR_RVALID),
    .DATA_REGION(DATA_REGION), .FETCH_REGION(FETCH_REGION), .DATA_CACHEABLE(DATA_CACHEABLE),
    .DATA_WRITETHROUGH(DATA_WRITETHROUGH), .FETCH_CACHEABLE(FETCH_CACHEABLE),
    .VECTOR_BASE(VECTOR_BASE));
`default_nettype wire

//--- testbench/csar_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "csar_regs_map.vh"
module tb;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [1:0]  RESET_KIND = 2'h2;
    logic [9:0]  SPR_NUM = 10'h000;
    logic        SPR_WR = 1'b0;
    logic        SPR_RD = 1'b0;
    logic [31:0] SPR_WDATA = 32'h00000000;
    logic        MSR_DBG_ALLOW = 1'b1;
    logic [12:0] evt = 13'h0000;
    logic        EXC_LOAD = 1'b0;
    logic [9:0]  exc = 10'h000;
    logic        DFA_LOAD = 1'b0;
    logic [31:0] DFA_ADDR = 32'h00000000;
    logic [4:0]  DATA_REGION = 5'h00;
    logic [4:0]  FETCH_REGION = 5'h00;
    wire  [31:0] SPR_RDATA;
    wire         SPR_RVALID, DATA_CACHEABLE, DATA_WRITETHROUGH, FETCH_CACHEABLE;
    wire  [15:0] VECTOR_BASE;
    int          bad_count = 0;
    int          tests_run = 0;
    logic [31:0] rd_val;
    logic [31:0] exp_val;
    logic [31:0] pat [2] = '{32'hffffffff, 32'h5a3c96e1};
    int          st_idx [13] = '{31, 30, 29, 28, 27, 26, 25, 24, 23, 22, 21, 19, 18};
    int          ex_idx [10] = '{31, 27, 26, 25, 24, 23, 22, 19, 18, 15};
    logic [9:0]  rg_num [11] = '{`CSAR_SPR_DVC_A, `CSAR_SPR_DVC_B, `CSAR_SPR_DWT_MAP,
        `CSAR_SPR_DFA, `CSAR_SPR_VBASE, `CSAR_SPR_IAC_A, `CSAR_SPR_IAC_B, `CSAR_SPR_DC_MAP,
        `CSAR_SPR_FC_MAP, `CSAR_SPR_EXC_CAUSE, 10'h3b0};
    logic [31:0] rg_mask [11] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        `CSAR_MASK_VBASE, `CSAR_MASK_IAC, `CSAR_MASK_IAC, 32'hffffffff, 32'hffffffff,
        `CSAR_MASK_EXC, 32'h00000000};

    csar_regbank DUT (.CLK(CLK), .SYS_RST(SYS_RST), .RESET_KIND(RESET_KIND),
        .SPR_NUM(SPR_NUM), .SPR_WR(SPR_WR), .SPR_RD(SPR_RD), .SPR_WDATA(SPR_WDATA),
        .SPR_RDATA(SPR_RDATA), .SPR_RVALID(SPR_RVALID), .MSR_DBG_ALLOW(MSR_DBG_ALLOW),
        .EVT_INSN_DONE(evt[0]), .EVT_BRANCH(evt[1]), .EVT_EXCEPTION(evt[2]),
        .EVT_TRAP(evt[3]), .EVT_UNCOND(evt[4]), .EVT_INSN_HIT_1(evt[5]),
        .EVT_INSN_HIT_2(evt[6]), .EVT_DATA_RD_HIT_1(evt[7]), .EVT_DATA_WR_HIT_1(evt[8]),
        .EVT_DATA_RD_HIT_2(evt[9]), .EVT_DATA_WR_HIT_2(evt[10]), .EVT_INSN_HIT_3(evt[11]),
        .EVT_INSN_HIT_4(evt[12]), .EXC_LOAD(EXC_LOAD), .FETCH_MACHINE_CHECK(exc[0]),
        .ILLEGAL_OP_FLAG(exc[1]), .PRIVILEGE_FAULT_FLAG(exc[2]), .TRAP_TAKEN_FLAG(exc[3]),
        .UNIMPLEMENTED_OP_FLAG(exc[4]), .STORE_FAULT_FLAG(exc[5]), .ZONE_FAULT_FLAG(exc[6]),
        .FLOAT_UNIT_FAULT_FLAG(exc[7]), .AUX_UNIT_FAULT_FLAG(exc[8]),
        .USER_ZERO_FAULT_FLAG(exc[9]), .DFA_LOAD(DFA_LOAD), .DFA_ADDR(DFA_ADDR),
        .DATA_REGION(DATA_REGION), .FETCH_REGION(FETCH_REGION),
        .DATA_CACHEABLE(DATA_CACHEABLE), .DATA_WRITETHROUGH(DATA_WRITETHROUGH),
        .FETCH_CACHEABLE(FETCH_CACHEABLE), .VECTOR_BASE(VECTOR_BASE));

    initial forever #12.5 CLK = ~CLK;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] num, input logic [31:0] data);
        @(posedge CLK);
        SPR_NUM   <= num;
        SPR_WDATA <= data;
        SPR_WR    <= 1'b1;
        @(posedge CLK);
        SPR_WR    <= 1'b0;
    endtask
    // bounded wait for the read answer; unknown result if none comes
    task automatic rd(input logic [9:0] num);
        @(posedge CLK);
        SPR_NUM <= num;
        SPR_RD  <= 1'b1;
        @(posedge CLK);
        SPR_RD  <= 1'b0;
        rd_val = 32'hxxxxxxxx;
        for (int n = 0; n < 5; n++) begin
            @(posedge CLK);
            #1;
            if (SPR_RVALID === 1'b1) begin
                rd_val = SPR_RDATA;
                break;
            end
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge CLK);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(`CSAR_SPR_DBG_STAT);
        chk(rd_val, 32'h00000200);
        for (int k = 1; k < 4; k++) begin
            @(posedge CLK);
            SYS_RST    <= 1'b1;
            RESET_KIND <= k[1:0];
            repeat (2) @(posedge CLK);
            SYS_RST    <= 1'b0;
            rd(`CSAR_SPR_DBG_STAT);
            chk(rd_val, {22'h000000, k[1:0], 8'h00});
        end
        wr(`CSAR_SPR_DBG_STAT, 32'hffffffff);
        rd(`CSAR_SPR_DBG_STAT);
        chk(rd_val, 32'h00000000);
        for (int i = 0; i < 13; i++) begin
            @(posedge CLK);
            evt <= 13'h0001 << i;
            @(posedge CLK);
            evt <= 13'h0000;
            rd(`CSAR_SPR_DBG_STAT);
            chk(rd_val, 32'h00000001 << st_idx[i]);
            wr(`CSAR_SPR_DBG_STAT, 32'hffffffff);
        end
        // event with debug interrupts disabled, then a partial clear
        @(posedge CLK);
        MSR_DBG_ALLOW <= 1'b0;
        evt <= 13'h0010;
        @(posedge CLK);
        evt <= 13'h0000;
        MSR_DBG_ALLOW <= 1'b1;
        rd(`CSAR_SPR_DBG_STAT);
        chk(rd_val, 32'h08100000);
        wr(`CSAR_SPR_DBG_STAT, 32'h08000000);
        rd(`CSAR_SPR_DBG_STAT);
        chk(rd_val, 32'h00100000);
        // an event in the clearing cycle keeps its bit
        @(posedge CLK);
        SPR_NUM   <= `CSAR_SPR_DBG_STAT;
        SPR_WDATA <= 32'hffffffff;
        SPR_WR    <= 1'b1;
        evt       <= 13'h0001;
        @(posedge CLK);
        SPR_WR    <= 1'b0;
        evt       <= 13'h0000;
        rd(`CSAR_SPR_DBG_STAT);
        chk(rd_val, 32'h80000000);
        for (int i = 0; i < 11; i++) begin
            @(posedge CLK);
            exc <= (i < 10) ? (10'h001 << i) : 10'h000;
            EXC_LOAD <= 1'b1;
            @(posedge CLK);
            EXC_LOAD <= 1'b0;
            rd(`CSAR_SPR_EXC_CAUSE);
            exp_val = (i < 10) ? (32'h00000001 << ex_idx[i]) : 32'h00000000;
            chk(rd_val, exp_val);
        end
        @(posedge CLK);
        DFA_ADDR <= 32'h87654321;
        DFA_LOAD <= 1'b1;
        @(posedge CLK);
        DFA_LOAD <= 1'b0;
        rd(`CSAR_SPR_DFA);
        chk(rd_val, 32'h87654321);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 11; i++) begin
                wr(rg_num[i], pat[p]);
                rd(rg_num[i]);
                chk(rd_val, pat[p] & rg_mask[i]);
                if (i == 4)
                    chk({16'h0000, VECTOR_BASE}, {16'h0000, pat[p][31:16]});
            end
        end
        wr(`CSAR_SPR_DC_MAP, 32'h80000001);
        wr(`CSAR_SPR_DWT_MAP, 32'h0000ffff);
        wr(`CSAR_SPR_FC_MAP, 32'h5a3c96e1);
        for (int i = 0; i < 32; i++) begin
            @(posedge CLK);
            DATA_REGION  <= i[4:0];
            FETCH_REGION <= 5'h1f - i[4:0];
            @(posedge CLK);
            #1;
            chk({31'h0, DATA_CACHEABLE}, {31'h0, i == 0 || i == 31});
            chk({31'h0, DATA_WRITETHROUGH}, {31'h0, i > 15});
            chk({31'h0, FETCH_CACHEABLE}, {31'h0, pat[1][i]});
        end
        end_of_test();
    end
endmodule
`default_nettype wire
